/* src/ddra_arbiter.sv */
/*
 Four-port priority round-robin arbiter in front of a controller command
 queue, with bandwidth hold-off and overflow, and an AXI4-Lite register
 slave. Assumes requests hold until granted, q_count/q_full describe the
 queue this cycle and port_busy marks cycles the core serves a port.
*/
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ddra_defs.svh"

module ddra_arbiter #(
  parameter int NPORT = 4,
  parameter int NGRP = 4,
  parameter int QCNT_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port requests and grants
  input wire ddra_pkg::ddra_req_t req,
  output logic [NPORT-1:0] grant,
  // Command queue
  input wire logic q_full,
  input wire logic [QCNT_W-1:0] q_count,
  input wire logic [NPORT-1:0] port_busy,
  output logic push_valid,
  output ddra_pkg::ddra_push_t push
);
  import ddra_pkg::*;

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [15:0] prio_q;
  logic [31:0] limit_q;
  logic [3:0] ovf_q;
  logic [7:0] thr_q;
  logic [3:0] phase_q;
  logic tick, upd_q;
  logic [NPORT-1:0] hold_q, grant_q;
  logic [NGRP-1:0][1:0] rr_q, rr_last_q;
  logic push_valid_q;
  ddra_push_t push_q;
  logic [NPORT-1:0][6:0] meas;
  logic [NPORT-1:0][1:0] pprio;
  logic [NPORT-1:0] elig, exceeded, ok;
  logic [NGRP-1:0][NPORT-1:0] member;
  logic [NGRP-1:0] nonexc_grp;
  logic all_full, below_thr;
  logic found;
  logic [1:0] win_port, win_grp;

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign grant = grant_q;
  assign push_valid = push_valid_q;
  assign push = push_q;

  ////////////////////////////////////////////////////////////////////////
  // Register slave: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `DDRA_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      prio_q <= `DDRA_PRIO_RST;
      limit_q <= `DDRA_LIMIT_RST;
      ovf_q <= 4'h0;
      thr_q <= `DDRA_THR_RST;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (!awready_q && !wready_q && !bvalid_q) begin
        bvalid_q <= 1'b1;
        bresp_q <= `DDRA_RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) begin
            case (awaddr_q)
              `DDRA_PRIO_OFS: if (b < 2) prio_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
              `DDRA_LIMIT_OFS: limit_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
              `DDRA_OVF_OFS: begin
                if (b == 0) ovf_q <= wdata_q[3:0];
                if (b == 1) thr_q <= wdata_q[15:8];
              end
              default: ;
            endcase
          end
        end
        if (awaddr_q != `DDRA_PRIO_OFS && awaddr_q != `DDRA_LIMIT_OFS && awaddr_q != `DDRA_OVF_OFS &&
            awaddr_q != `DDRA_MEAS_OFS && awaddr_q != `DDRA_HOLD_OFS) begin
          bresp_q <= `DDRA_RESP_SLVERR;
        end
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `DDRA_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `DDRA_RESP_OKAY;
      case (s_axi_araddr)
        `DDRA_PRIO_OFS: rdata_q <= {16'h0000, prio_q};
        `DDRA_LIMIT_OFS: rdata_q <= limit_q;
        `DDRA_OVF_OFS: rdata_q <= {16'h0000, thr_q, 4'h0, ovf_q};
        `DDRA_MEAS_OFS: rdata_q <= {1'b0, meas[3], 1'b0, meas[2], 1'b0, meas[1], 1'b0, meas[0]};
        `DDRA_HOLD_OFS: rdata_q <= {28'h000_0000, hold_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `DDRA_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reporting interval: hold-off is judged once per interval, not per cycle
  assign tick = (phase_q == 4'(`DDRA_REPORT_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 4'h0;
      upd_q <= 1'b0;
    end else begin
      phase_q <= tick ? 4'h0 : phase_q + 4'h1;
      upd_q <= tick;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= '0;
    end else if (upd_q) begin
      for (int p = 0; p < NPORT; p++) begin
        hold_q[p] <= (meas[p] >= limit_q[p*8 +: 7]);
      end
    end
  end

  assign all_full = (limit_q[6:0] >= 7'(`DDRA_FULL_PCT)) && (limit_q[14:8] >= 7'(`DDRA_FULL_PCT)) &&
                    (limit_q[22:16] >= 7'(`DDRA_FULL_PCT)) && (limit_q[30:24] >= 7'(`DDRA_FULL_PCT));
  assign below_thr = (q_count < QCNT_W'(thr_q));

  ////////////////////////////////////////////////////////////////////////
  // Per-port grouping, meter and eligibility
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    assign pprio[p] = req.is_write[p] ? prio_q[p*4+2 +: 2] : prio_q[p*4 +: 2];
    // The port granted last cycle is still dropping its request
    assign elig[p] = req.valid[p] && !grant_q[p];
    assign exceeded[p] = hold_q[p] && !all_full;
    assign ok[p] = !exceeded[p] || (ovf_q[p] && !nonexc_grp[pprio[p]] && below_thr);
    for (genvar g = 0; g < NGRP; g++) begin : g_grp
      assign member[g][p] = elig[p] && (pprio[p] == 2'(g));
    end
    ddra_bw_meter u_meter (
      .aclk(aclk),
      .aresetn(aresetn),
      .busy(port_busy[p]),
      .tick(tick),
      .meas(meas[p])
    );
  end

  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      nonexc_grp[g] = |(member[g] & ~exceeded);
    end
  end

  // Group 0 first, then upward; inside each group, circular from the counter
  always_comb begin
    int idx;
    idx = 0;
    found = 1'b0;
    win_port = 2'h0;
    win_grp = 2'h0;
    for (int g = 0; g < NGRP; g++) begin
      for (int k = 0; k < NPORT; k++) begin
        idx = (int'(rr_q[g]) + k) % NPORT;
        if (!found && member[g][idx] && ok[idx]) begin
          found = 1'b1;
          win_port = 2'(idx);
          win_grp = 2'(g);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_q <= '0;
      push_valid_q <= 1'b0;
      push_q <= '0;
    end else begin
      grant_q <= '0;
      push_valid_q <= 1'b0;
      if (found && !q_full) begin
        grant_q[win_port] <= 1'b1;
        push_valid_q <= 1'b1;
        push_q <= '{port: win_port, is_write: req.is_write[win_port], prio: win_grp};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rr_q <= '0;
    end else if (found && !q_full) begin
      rr_q[win_grp] <= (int'(rr_q[win_grp]) == NPORT - 1) ? 2'h0 : rr_q[win_grp] + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Per-port copies of the deciding cycle, indexed later by the winner
  logic [NPORT-1:0] req_last_q, gate_last_q;
  logic [NPORT-1:0][1:0] pprio_last_q;

  always_ff @(posedge aclk) begin
    rr_last_q <= rr_q;
    req_last_q <= req.valid;
    pprio_last_q <= pprio;
    for (int p = 0; p < NPORT; p++) begin
      gate_last_q[p] <= !exceeded[p] || (ovf_q[p] && below_thr && !nonexc_grp[pprio[p]]);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_push_seen;
    push_valid_q ##0 grant_q[push_q.port];
  endsequence

  a_full_no_grant: assert property (q_full |=> !push_valid_q && grant_q == '0)
    else $error("grant issued while queue full");
  a_full_rr_frozen: assert property (q_full |=> rr_q == $past(rr_q))
    else $error("counter moved while queue full");
  a_rr_one_step: assert property (s_push_seen |-> rr_q[push_q.prio] ==
      2'((int'(rr_last_q[push_q.prio]) + 1) % NPORT))
    else $error("winning group counter did not step by one");
  a_hold_stable: assert property (!upd_q |=> hold_q == $past(hold_q))
    else $error("hold-off changed inside an interval");
  a_meas_period: assert property (meas != $past(meas) |-> $past(tick))
    else $error("bandwidth updated off the reporting boundary");
  a_meas_window: assert property (meas[0] <= 7'(`DDRA_WINDOW_CYC))
    else $error("measured bandwidth exceeds window");
  a_overflow_gate: assert property (push_valid_q |-> gate_last_q[push_q.port])
    else $error("exceeded port won without overflow conditions");
  a_group_source: assert property (push_valid_q |-> req_last_q[push_q.port] &&
      push_q.prio == pprio_last_q[push_q.port])
    else $error("winner group or request mismatch");
endmodule

/* pkg/ddra_defs.svh */
/*
 Constants of the port arbiter: register offsets, field positions,
 reset values and measurement timing. Assumes inclusion by bare name.
*/
`ifndef DDRA_DEFS_SVH
`define DDRA_DEFS_SVH

// Register byte offsets
`define DDRA_PRIO_OFS 8'h00
`define DDRA_LIMIT_OFS 8'h04
`define DDRA_OVF_OFS 8'h08
`define DDRA_MEAS_OFS 8'h0C
`define DDRA_HOLD_OFS 8'h10

// Field layout: per port nibble in PRIO, byte in LIMIT and MEAS
`define DDRA_OVF_THR_LSB 8
`define DDRA_PRIO_RST 16'h5555
`define DDRA_LIMIT_RST 32'h6464_6464
`define DDRA_THR_RST 8'h08

// Timing in cycles; full-limit threshold in percent
`define DDRA_REPORT_CYC 10
`define DDRA_WINDOW_CYC 100
`define DDRA_FULL_PCT 100

`define DDRA_RESP_OKAY 2'b00
`define DDRA_RESP_SLVERR 2'b10

`endif

/* pkg/ddra_pkg.sv */
/*
 Types of the port arbiter. Assumes a four-port controller core.
*/
package ddra_pkg;
  typedef struct packed {
    logic [1:0] port;
    logic is_write;
    logic [1:0] prio;
  } ddra_push_t;

  typedef struct packed {
    logic [3:0] valid;
    logic [3:0] is_write;
  } ddra_req_t;
endpackage

/* src/ddra_bw_meter.sv */
/*
 Moving bandwidth meter for one port: ten interval counts form a
 sliding window. Assumes tick pulses on the last cycle of each interval.
*/
`timescale 1ns/1ps
`include "ddra_defs.svh"

module ddra_bw_meter #(
  parameter int NBUCKET = `DDRA_WINDOW_CYC / `DDRA_REPORT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Activity
  input wire logic busy,
  input wire logic tick,
  // Result in percent of the window
  output logic [6:0] meas
);
  import ddra_pkg::*;

  logic [3:0] cur_q;
  logic [3:0] bucket_q [NBUCKET];
  logic [3:0] idx_q;
  logic [6:0] meas_q;
  logic [3:0] cur_fin;

  assign cur_fin = cur_q + {3'h0, busy};
  assign meas = meas_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_q <= 4'h0;
      idx_q <= 4'h0;
      meas_q <= 7'h00;
      for (int i = 0; i < NBUCKET; i++) begin
        bucket_q[i] <= 4'h0;
      end
    end else if (tick) begin
      // Oldest interval leaves the sum as the newest enters
      meas_q <= meas_q - {3'h0, bucket_q[idx_q]} + {3'h0, cur_fin};
      bucket_q[idx_q] <= cur_fin;
      idx_q <= (idx_q == 4'(NBUCKET - 1)) ? 4'h0 : idx_q + 4'h1;
      cur_q <= 4'h0;
    end else begin
      cur_q <= cur_fin;
    end
  end
endmodule

/* bench/ddra_queue_model.sv */
/*
 Command queue beside the arbiter: pushes enter, the head executes EXEC
 cycles, then leaves. Assumes one entry per push_valid pulse.
*/
`timescale 1ns/1ps

module ddra_queue_model #(
  parameter int DEPTH = 8,
  parameter int EXEC = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Arbiter side
  input wire logic push_valid,
  input wire ddra_pkg::ddra_push_t push,
  input wire logic stall,
  // Queue state
  output logic q_full,
  output logic [7:0] q_count,
  output logic [3:0] port_busy
);
  import ddra_pkg::*;
  logic [1:0] fifo_q[$];
  int run_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      fifo_q = {};
      run_q = 0;
    end else begin
      if (run_q == EXEC) begin
        void'(fifo_q.pop_front());
        run_q = 0;
      end
      if (push_valid) fifo_q.push_back(push.port);
      if (fifo_q.size() > 0 && !stall) run_q++;
    end
    q_full <= fifo_q.size() >= DEPTH;
    q_count <= 8'(fifo_q.size());
    // Waiting entries never count as busy, only the executing head
    port_busy <= run_q > 0 ? 4'b0001 << fifo_q[0] : 4'b0000;
  end
endmodule

/* bench/tb.sv */
/*
 Bench of the port arbiter: register checks, random round-robin traffic
 against a reference, hold-off and overflow. Assumes ddra_queue_model.
*/
`timescale 1ns/1ps
`include "ddra_defs.svh"

module tb;
  import ddra_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, chk;
  logic stall = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, q_full, push_valid;
  logic [7:0] awaddr, araddr, q_count;
  logic [31:0] wdata, rdata, seed;
  logic [1:0] bresp, rresp, mode;
  logic [3:0] grant, port_busy, exp_g;
  logic [15:0] prio;
  logic [1:0] rr_q[4];
  ddra_req_t rq = '0;
  ddra_push_t push, exp_p;
  int err_total = 0;
  int comparisons = 0;
  int cyc_q = 0;

  ddra_arbiter DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req(rq), .grant(grant),
    .q_full(q_full), .q_count(q_count), .port_busy(port_busy), .push_valid(push_valid), .push(push));
  ddra_queue_model u_queue (.aclk(aclk), .aresetn(aresetn), .push_valid(push_valid), .push(push),
    .stall(stall), .q_full(q_full), .q_count(q_count), .port_busy(port_busy));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [1:0] grp(input int p, input logic w);
    return w ? prio[4*p+2 +: 2] : prio[4*p +: 2];
  endfunction

  task automatic end_sim();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] ers);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    check(rdata, exp, "read data");
    check(32'(rresp), 32'(ers), "read response");
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] ers);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check(32'(bresp), 32'(ers), "write response");
  endtask

  // Port 0 alone requests; measure longest stretch without a grant
  task automatic bw_stage(input logic [31:0] ovf, input logic held);
    int g, m, k;
    g = 0;
    m = 0;
    k = 0;
    wr_chk(`DDRA_OVF_OFS, ovf, `DDRA_RESP_OKAY);
    repeat (300) begin
      @(posedge aclk);
      g = grant[0] ? 0 : g + 1;
      m = g > m ? g : m;
      k = k + 32'(grant[0]);
    end
    check({30'h0, m >= 10, k > 0}, {30'h0, held, 1'b1}, "hold-off gaps");
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    logic [31:0] r;
    logic [3:0] e;
    int w, p;
    r = rnd();
    cyc_q <= cyc_q + 1;
    if (cyc_q == 10000) begin
      err_total++;
      $display("ERROR at %0t: timeout", $time);
      end_sim();
    end
    if (chk) check(32'({grant, push_valid, |exp_g ? push : 5'h0}), 32'({exp_g, |exp_g, exp_p}), "grant");
    if (!aresetn) begin
      rr_q = '{default: 2'd0};
      exp_g = 4'h0;
      exp_p = '0;
    end else begin
      e = rq.valid & ~grant;
      exp_g = 4'h0;
      exp_p = 5'h0;
      w = -1;
      if (!q_full) begin
        for (int g = 0; g < 4; g++)
          for (int k = 0; k < 4; k++) begin
            p = (rr_q[g] + k) % 4;
            if (w < 0 && e[p] && grp(p, rq.is_write[p]) == g) begin
              w = p;
              exp_p = '{2'(p), rq.is_write[p], 2'(g)};
              rr_q[g] = rr_q[g] + 2'd1;
            end
          end
      end
      if (w >= 0) exp_g[w] = 1'b1;
    end
    stall <= mode == 2'd1 && r[31:30] == 2'b11;
    for (int q = 0; q < 4; q++)
      if (grant[q]) rq.valid[q] <= 1'b0;
      else if (!rq.valid[q] && (mode == 2'd1 && r[q] || mode == 2'd2 && q == 0)) begin
        rq.valid[q] <= 1'b1;
        rq.is_write[q] <= r[q+4];
      end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    seed = 32'h0000_eb3d;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, chk} = 7'h00;
    {awaddr, araddr, wdata, mode} = '0;
    prio = `DDRA_PRIO_RST;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk <= 1'b1;
    rd_chk(`DDRA_PRIO_OFS, `DDRA_PRIO_RST, `DDRA_RESP_OKAY);
    rd_chk(`DDRA_LIMIT_OFS, `DDRA_LIMIT_RST, `DDRA_RESP_OKAY);
    rd_chk(`DDRA_OVF_OFS, {16'h0000, `DDRA_THR_RST, 8'h00}, `DDRA_RESP_OKAY);
    rd_chk(8'h14, 32'h0000_0000, `DDRA_RESP_SLVERR);
    wr_chk(8'h14, 32'hffff_ffff, `DDRA_RESP_SLVERR);
    wr_chk(`DDRA_MEAS_OFS, 32'hffff_ffff, `DDRA_RESP_OKAY);
    rd_chk(`DDRA_MEAS_OFS, 32'h0000_0000, `DDRA_RESP_OKAY);
    // Every level used once for reads and once for writes
    for (int ph = 0; ph < 4; ph++) begin
      v = {4{2'(3 - ph), 2'(ph)}};
      wr_chk(`DDRA_PRIO_OFS, {16'h0000, v}, `DDRA_RESP_OKAY);
      rd_chk(`DDRA_PRIO_OFS, {16'h0000, v}, `DDRA_RESP_OKAY);
      prio = v;
      mode <= 2'd1;
      repeat (400) @(posedge aclk);
      mode <= 2'd0;
      repeat (40) @(posedge aclk);
    end
    chk <= 1'b0;
    wr_chk(`DDRA_LIMIT_OFS, 32'h6464_6405, `DDRA_RESP_OKAY);
    mode <= 2'd2;
    bw_stage(32'h0000_0800, 1'b1);
    bw_stage(32'h0000_0801, 1'b0);
    bw_stage(32'h0000_0001, 1'b1);
    end_sim();
  end
endmodule
